// ==== pdc_pll_ctrl.v ====
// pll configuration registers, dynamic delay/phase/duty decode, lock
`timescale 1ns/1ps
`include "pdc_defines.vh"
// Notes on behaviour
// - dynamic select high takes fine delay inputs only when the delay mode bit is set
// - zero forces none; lead/lag by code+1
// - static delay signed steps -8 to +8
// - static delay mode ignores dynamic delay inputs
// - phase/duty from codes when dynamic selected
// - phase equals code times 22.5 degrees
// - duty codes 2..14 only; others unsupported
// - lock only after lock time elapses
// - reference and feedback dividers 1..64, default 1
// - main divider from fixed list, default 8
// - slow divider even 2..128, default 2
// - bypass routes reference clock to output
// - feedback from tap, tree or user
// - static phase in 22.5 degree steps
// - static duty steps 2 to 14 only
// - fine delay only driven out on delay_steps_out; no clock output is delayed
// - active high pll reset clears counters
module pdc_pll_ctrl #(
    parameter LOCK_TIME_NS = `PDC_LOCK_TIME_NS,
    parameter LOCK_CYCLES  = (LOCK_TIME_NS + `PDC_CLK_PERIOD_NS - 1) /
                             `PDC_CLK_PERIOD_NS
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        delay_source_sel,
    input  wire        delay_zero,
    input  wire        delay_lead_sel,
    input  wire [2:0]  delay_step_code,
    input  wire        phase_duty_source_sel,
    input  wire [3:0]  phase_code,
    input  wire [3:0]  duty_code,
    input  wire        ref_clock_in,
    input  wire        fb_clock_in,
    output reg         main_clock_out,
    output reg         shifted_clock_out,
    output reg         slow_clock_out,
    output reg         fb_clock_sel,
    output reg         lock,
    output reg  [4:0]  delay_steps_out,
    output reg  [3:0]  phase_out,
    output reg  [3:0]  duty_out
);
    // configuration registers
    reg        pll_reset_reg;
    reg        delay_mode_attr_reg;
    reg        phase_duty_mode_attr_reg;
    reg [1:0]  feedback_source_sel_reg;
    reg [2:0]  bypass_reg;
    reg [6:0]  ref_divider_reg;
    reg [6:0]  fb_divider_reg;
    reg [7:0]  main_out_divider_reg;
    reg [7:0]  slow_out_divider_reg;
    reg [4:0]  static_delay_steps_reg;
    reg [3:0]  static_phase_attr_reg;
    reg [3:0]  static_duty_reg;
    reg        duty_bad_reg;
    reg [31:0] lock_cnt_reg;
    reg [3:0]  slot_reg;
    reg        ref_q_reg;

    // apb decode: access phase waits one cycle, then pready
    wire acc    = psel & penable & ~pready;
    wire commit = psel & penable & pready;
    wire wr     = commit & pwrite & ~pslverr;
    wire mapped = (paddr == `PDC_CTRL_OFS) | (paddr == `PDC_DIV_OFS) |
                  (paddr == `PDC_ADJ_OFS) | (paddr == `PDC_STAT_OFS);

    // field legality checks
    wire [6:0] w_ref  = pwdata[`PDC_DIV_REF_MSB:`PDC_DIV_REF_LSB];
    wire [6:0] w_fb   = pwdata[`PDC_DIV_FB_MSB:`PDC_DIV_FB_LSB];
    wire [7:0] w_main = pwdata[`PDC_DIV_MAIN_MSB:`PDC_DIV_MAIN_LSB];
    wire [7:0] w_slow = pwdata[`PDC_DIV_SLOW_MSB:`PDC_DIV_SLOW_LSB];
    wire [4:0] w_dly  = pwdata[`PDC_ADJ_DLY_MSB:`PDC_ADJ_DLY_LSB];
    wire [3:0] w_ph   = pwdata[`PDC_ADJ_PH_MSB:`PDC_ADJ_PH_LSB];
    wire [3:0] w_du   = pwdata[`PDC_ADJ_DU_MSB:`PDC_ADJ_DU_LSB];
    wire ref_ok  = (w_ref != 7'h00) & (w_ref <= `PDC_DIV_MAX_64);
    wire fb_ok   = (w_fb != 7'h00) & (w_fb <= `PDC_DIV_MAX_64);
    wire main_ok = (w_main == 8'h02) | (w_main == 8'h04) |
                   (w_main == 8'h08) | (w_main == 8'h10) |
                   ((w_main[3:0] == 4'h0) & (w_main >= 8'h20) &
                    (w_main <= `PDC_DIV_MAX_128));
    wire slow_ok = ~w_slow[0] & (w_slow >= `PDC_DIV_MIN_EVEN) &
                   (w_slow <= `PDC_DIV_MAX_128);
    wire dly_ok  = ($signed(w_dly) >= $signed(`PDC_DLY_MIN)) &
                   ($signed(w_dly) <= $signed(`PDC_DLY_MAX));
    wire du_ok   = (w_du >= `PDC_DUTY_MIN) &
                   (w_du <= `PDC_DUTY_MAX);

    // effective source selection
    wire dly_dyn = delay_mode_attr_reg & delay_source_sel;
    wire pd_dyn  = phase_duty_mode_attr_reg & phase_duty_source_sel;
    wire [4:0] step_mag = {2'b00, delay_step_code} + 5'h01;
    wire [4:0] dyn_dly  = delay_zero ? 5'h00 :
                          (delay_lead_sel ? (~step_mag + 5'h01) :
                           step_mag);
    wire [4:0] delay_next = dly_dyn ? dyn_dly :
                            static_delay_steps_reg;
    wire       dyn_du_ok  = (duty_code >= `PDC_DUTY_MIN) &
                            (duty_code <= `PDC_DUTY_MAX);
    wire [3:0] phase_next = pd_dyn ? phase_code :
                            static_phase_attr_reg;
    wire [3:0] duty_next  = pd_dyn ? (dyn_du_ok ? duty_code : duty_out) :
                            static_duty_reg;

    // divider levels, pll reset hold and phase slot offset
    wire main_lvl;
    wire main_tick;
    wire slow_lvl;
    wire hold = pll_reset_reg;
    wire [3:0] slot_ofs = slot_reg - phase_out;

    // apb register writes and read data
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready                   <= 1'b0;
            pslverr                  <= 1'b0;
            prdata                   <= 32'h00000000;
            pll_reset_reg            <= 1'b0;
            delay_mode_attr_reg      <= 1'b0;
            phase_duty_mode_attr_reg <= 1'b0;
            feedback_source_sel_reg  <= `PDC_FB_TREE;
            bypass_reg               <= 3'h0;
            ref_divider_reg          <= `PDC_REF_DIV_RST;
            fb_divider_reg           <= `PDC_FB_DIV_RST;
            main_out_divider_reg     <= `PDC_MAIN_DIV_RST;
            slow_out_divider_reg     <= `PDC_SLOW_DIV_RST;
            static_delay_steps_reg   <= 5'h00;
            static_phase_attr_reg    <= 4'h0;
            static_duty_reg          <= `PDC_DUTY_RST;
        end else begin
            pready  <= acc;
            pslverr <= acc & ~mapped;
            if (acc) begin
                prdata <= 32'h00000000;
                case (paddr)
                `PDC_CTRL_OFS: prdata <= {24'h000000, bypass_reg,
                                   feedback_source_sel_reg,
                                   phase_duty_mode_attr_reg,
                                   delay_mode_attr_reg, pll_reset_reg};
                `PDC_DIV_OFS:  prdata <= {slow_out_divider_reg,
                                   main_out_divider_reg, 1'b0,
                                   fb_divider_reg, 1'b0, ref_divider_reg};
                `PDC_ADJ_OFS:  prdata <= {16'h0000, static_duty_reg,
                                   static_phase_attr_reg, 3'h0,
                                   static_delay_steps_reg};
                `PDC_STAT_OFS: prdata <= {8'h00, duty_out, phase_out,
                                   3'h0, delay_steps_out, 4'h0,
                                   duty_bad_reg, pd_dyn, dly_dyn, lock};
                default:       prdata <= 32'h00000000;
                endcase
            end
            if (wr && paddr == `PDC_CTRL_OFS) begin
                pll_reset_reg            <= pwdata[`PDC_CTRL_RST_BIT];
                delay_mode_attr_reg      <= pwdata[`PDC_CTRL_DLYM_BIT];
                phase_duty_mode_attr_reg <= pwdata[`PDC_CTRL_PDM_BIT];
                if (pwdata[`PDC_CTRL_FB_MSB:`PDC_CTRL_FB_LSB] <= `PDC_FB_USER)
                    feedback_source_sel_reg <=
                        pwdata[`PDC_CTRL_FB_MSB:`PDC_CTRL_FB_LSB];
                bypass_reg <= pwdata[`PDC_CTRL_BYPK_BIT:`PDC_CTRL_BYPM_BIT];
            end
            // illegal field values are dropped, the old value stays
            if (wr && paddr == `PDC_DIV_OFS) begin
                if (ref_ok)
                    ref_divider_reg <= w_ref;
                if (fb_ok)
                    fb_divider_reg <= w_fb;
                if (main_ok)
                    main_out_divider_reg <= w_main;
                if (slow_ok)
                    slow_out_divider_reg <= w_slow;
            end
            if (wr && paddr == `PDC_ADJ_OFS) begin
                if (dly_ok)
                    static_delay_steps_reg <= w_dly;
                static_phase_attr_reg <= w_ph;
                if (du_ok)
                    static_duty_reg <= w_du;
            end
        end
    end

    // decoded controls follow inputs every cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delay_steps_out <= 5'h00;
            phase_out       <= 4'h0;
            duty_out        <= `PDC_DUTY_RST;
            duty_bad_reg    <= 1'b0;
        end else begin
            delay_steps_out <= delay_next;
            phase_out       <= phase_next;
            duty_out        <= duty_next;
            duty_bad_reg    <= pd_dyn & ~dyn_du_ok;
        end
    end

    // lock timer restarts on pll reset or a dynamic delay jump
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_cnt_reg <= 32'h00000000;
            lock         <= 1'b0;
        end else if (hold || (dly_dyn && delay_next != delay_steps_out)) begin
            lock_cnt_reg <= 32'h00000000;
            lock         <= 1'b0;
        end else if (lock_cnt_reg == LOCK_CYCLES - 1) begin
            lock <= 1'b1;
        end else begin
            lock_cnt_reg <= lock_cnt_reg + 32'h00000001;
        end
    end

    // main divider runs on pclk as the oscillator model
    pdc_div #(.W(8)) u_main_div (
        .clk   (pclk),
        .rst_n (presetn),
        .clr   (hold),
        .en    (1'b1),
        .div   (main_out_divider_reg),
        .level (main_lvl),
        .tick  (main_tick)
    );

    // slow divider counts main periods
    pdc_div #(.W(8)) u_slow_div (
        .clk   (pclk),
        .rst_n (presetn),
        .clr   (hold),
        .en    (main_tick),
        .div   (slow_out_divider_reg),
        .level (slow_lvl),
        .tick  ()
    );

    // output muxes: bypass, phase/duty shaping and feedback select
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_q_reg         <= 1'b0;
            slot_reg          <= 4'h0;
            main_clock_out    <= 1'b0;
            shifted_clock_out <= 1'b0;
            slow_clock_out    <= 1'b0;
            fb_clock_sel      <= 1'b0;
        end else begin
            ref_q_reg <= ref_clock_in;
            slot_reg  <= hold ? 4'h0 : slot_reg + 4'h1;
            main_clock_out    <= bypass_reg[0] ? ref_q_reg :
                                 main_lvl;
            shifted_clock_out <= bypass_reg[1] ? ref_q_reg :
                                 (slot_ofs < duty_out);
            slow_clock_out    <= bypass_reg[2] ? ref_q_reg :
                                 slow_lvl;
            case (feedback_source_sel_reg)
            `PDC_FB_INTERNAL: fb_clock_sel <= main_lvl;
            `PDC_FB_TREE:     fb_clock_sel <= main_clock_out;
            `PDC_FB_USER:     fb_clock_sel <= fb_clock_in;
            default:          fb_clock_sel <= main_clock_out;
            endcase
        end
    end
    // the delay value only leaves on delay_steps_out; no clock output path uses it
endmodule

// ==== pdc_defines.vh ====
// constants for the pll configuration and dynamic control block
`ifndef PDC_DEFINES_VH
`define PDC_DEFINES_VH
// register byte offsets
`define PDC_CTRL_OFS        8'h00
`define PDC_DIV_OFS         8'h04
`define PDC_ADJ_OFS         8'h08
`define PDC_STAT_OFS        8'h0C
// control register fields
`define PDC_CTRL_RST_BIT    0
`define PDC_CTRL_DLYM_BIT   1
`define PDC_CTRL_PDM_BIT    2
`define PDC_CTRL_FB_LSB     3
`define PDC_CTRL_FB_MSB     4
`define PDC_CTRL_BYPM_BIT   5
`define PDC_CTRL_BYPS_BIT   6
`define PDC_CTRL_BYPK_BIT   7
// divider register fields
`define PDC_DIV_REF_LSB     0
`define PDC_DIV_REF_MSB     6
`define PDC_DIV_FB_LSB      8
`define PDC_DIV_FB_MSB      14
`define PDC_DIV_MAIN_LSB    16
`define PDC_DIV_MAIN_MSB    23
`define PDC_DIV_SLOW_LSB    24
`define PDC_DIV_SLOW_MSB    31
// adjust register fields
`define PDC_ADJ_DLY_LSB     0
`define PDC_ADJ_DLY_MSB     4
`define PDC_ADJ_PH_LSB      8
`define PDC_ADJ_PH_MSB      11
`define PDC_ADJ_DU_LSB      12
`define PDC_ADJ_DU_MSB      15
// feedback source codes
`define PDC_FB_INTERNAL     2'h0
`define PDC_FB_TREE         2'h1
`define PDC_FB_USER         2'h2
// reset values
`define PDC_REF_DIV_RST     7'h01
`define PDC_FB_DIV_RST      7'h01
`define PDC_MAIN_DIV_RST    8'h08
`define PDC_SLOW_DIV_RST    8'h02
`define PDC_DUTY_RST        4'h8
// legal ranges
`define PDC_DIV_MAX_64      7'h40
`define PDC_DIV_MAX_128     8'h80
`define PDC_DIV_MIN_EVEN    8'h02
`define PDC_DUTY_MIN        4'h2
`define PDC_DUTY_MAX        4'hE
`define PDC_DLY_MIN         5'h18
`define PDC_DLY_MAX         5'h08
// timing
`define PDC_DELAY_STEP_PS   130
`define PDC_CLK_PERIOD_NS   50
`define PDC_LOCK_TIME_NS    100000
`endif

// ==== pdc_div.v ====
// even clock divider producing a square level and a period tick
`timescale 1ns/1ps
`include "pdc_defines.vh"
module pdc_div #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         clr,
    input  wire         en,
    input  wire [W-1:0] div,
    output reg          level,
    output reg          tick
);
    reg [W-1:0] cnt_reg;
    wire [W-1:0] half = {1'b0, div[W-1:1]};

    // count enable pulses; toggle at half period, tick on wrap
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= {W{1'b0}};
            level   <= 1'b0;
            tick    <= 1'b0;
        end else if (clr) begin
            cnt_reg <= {W{1'b0}};
            level   <= 1'b0;
            tick    <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (en) begin
                if (cnt_reg == div - {{(W-1){1'b0}}, 1'b1}) begin
                    cnt_reg <= {W{1'b0}};
                    level   <= 1'b0;
                    tick    <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
                    if (cnt_reg == half - {{(W-1){1'b0}}, 1'b1})
                        level <= 1'b1;
                end
            end
        end
    end
endmodule

// ==== pdc_checker.sv ====
// concurrent checks on the pll control block ports
`timescale 1ns/1ps
module pdc_checker #(
    parameter LOCK_CYCLES = 2000
) (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] pwdata,
    input logic        pready,
    input logic        pslverr,
    input logic        delay_source_sel,
    input logic        delay_zero,
    input logic        delay_lead_sel,
    input logic [2:0]  delay_step_code,
    input logic        phase_duty_source_sel,
    input logic [3:0]  phase_code,
    input logic [3:0]  duty_code,
    input logic        lock,
    input logic [4:0]  delay_steps_out,
    input logic [3:0]  phase_out,
    input logic [3:0]  duty_out
);
    logic dly_m;
    logic pd_m;
    logic wr_d;
    int   lo_cnt;
    wire  dyn_d  = dly_m && delay_source_sel;
    wire  dyn_p  = pd_m && phase_duty_source_sel;
    wire  du_ok  = duty_code inside {[4'h2:4'hE]};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // mirror the mode bits, recent writes and time spent unlocked
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_m  <= 1'b0;
            pd_m   <= 1'b0;
            wr_d   <= 1'b0;
            lo_cnt <= 0;
        end else begin
            wr_d   <= psel && pwrite;
            lo_cnt <= lock ? 0 : lo_cnt + 1;
            if (psel && penable && pready && pwrite && paddr == 8'h00) begin
                dly_m <= pwdata[1];
                pd_m  <= pwdata[2];
            end
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_one_wait;
        penable && !pready ##1 pready;
    endsequence
    a_apb_one_wait: assert property (s_setup |=> s_one_wait)
        else $error("apb answer not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_map: assert property (pready |->
        pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
        else $error("pslverr does not match address map");
    a_dly_zero: assert property (
        dyn_d && delay_zero |=> delay_steps_out == 5'h00)
        else $error("zero delay not applied");
    a_dly_lead: assert property (
        dyn_d && !delay_zero && delay_lead_sel
        |=> delay_steps_out == {2'b11, ~$past(delay_step_code)})
        else $error("lead delay wrong");
    a_dly_lag: assert property (
        dyn_d && !delay_zero && !delay_lead_sel
        |=> delay_steps_out == {2'b00, $past(delay_step_code)} + 5'h01)
        else $error("lag delay wrong");
    a_static_hold: assert property (
        !dly_m && !(psel && pwrite) && !wr_d |=> $stable(delay_steps_out))
        else $error("delay moved in static mode");
    a_phase_dyn: assert property (
        dyn_p |=> phase_out == $past(phase_code))
        else $error("dynamic phase wrong");
    a_duty_dyn: assert property (
        dyn_p && du_ok |=> duty_out == $past(duty_code))
        else $error("dynamic duty wrong");
    a_duty_refused: assert property (
        dyn_p && !du_ok |=> $stable(duty_out))
        else $error("unsupported duty applied");
    a_lock_wait: assert property (
        $rose(lock) |-> lo_cnt >= LOCK_CYCLES - 1)
        else $error("lock rose too early");
endmodule
bind pdc_pll_ctrl pdc_checker #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .delay_source_sel, .delay_zero, .delay_lead_sel,
    .delay_step_code, .phase_duty_source_sel, .phase_code, .duty_code,
    .lock, .delay_steps_out, .phase_out, .duty_out
);

// ==== pdc_fabric_model.sv ====
// fabric-side model driving the dynamic delay, phase and duty inputs
`timescale 1ns/1ps
module pdc_fabric_model (
    input  logic        pclk,
    input  logic        presetn,
    input  logic [14:0] cmd,
    output logic        delay_source_sel,
    output logic        delay_zero,
    output logic        delay_lead_sel,
    output logic [2:0]  delay_step_code,
    output logic        phase_duty_source_sel,
    output logic [3:0]  phase_code,
    output logic [3:0]  duty_code
);
    // both code buses always driven as levels from one command word
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {delay_source_sel, delay_zero, delay_lead_sel} <= 3'h0;
            delay_step_code <= 3'h0;
            {phase_duty_source_sel, phase_code, duty_code} <= 9'h008;
        end else begin
            {delay_source_sel, delay_zero, delay_lead_sel, delay_step_code,
             phase_duty_source_sel, phase_code, duty_code} <= cmd;
        end
    end
endmodule

// ==== pdc_pll_ctrl_tb_top.sv ====
// self-checking bench for the pll control block
`timescale 1ns/1ps
`include "pdc_defines.vh"
module pdc_pll_ctrl_tb_top;
    localparam int LOCK_N = 8;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        rerr, lock, fb_clock_sel, fb_clock_in;
    logic        ref_clock_in = 1'b0;
    logic        main_clock_out, shifted_clock_out, slow_clock_out;
    logic        delay_source_sel, delay_zero, delay_lead_sel;
    logic        phase_duty_source_sel;
    logic [2:0]  delay_step_code;
    logic [3:0]  phase_code, duty_code, phase_out, duty_out;
    logic [4:0]  delay_steps_out;
    logic [7:0]  paddr;
    logic [14:0] cmd;
    logic [31:0] pwdata, prdata, rdata;
    logic [27:0] rows [7];
    int          num_errors = 0;
    int          cmp_count = 0;
    int          n;
    int          hi [4];
    int          up [4];

    pdc_pll_ctrl #(.LOCK_CYCLES(LOCK_N)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .delay_source_sel, .delay_zero,
        .delay_lead_sel, .delay_step_code, .phase_duty_source_sel,
        .phase_code, .duty_code, .ref_clock_in, .fb_clock_in,
        .main_clock_out, .shifted_clock_out, .slow_clock_out,
        .fb_clock_sel, .lock, .delay_steps_out, .phase_out, .duty_out
    );
    pdc_fabric_model fab (
        .pclk, .presetn, .cmd, .delay_source_sel, .delay_zero,
        .delay_lead_sel, .delay_step_code, .phase_duty_source_sel,
        .phase_code, .duty_code
    );

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // one apb transfer: setup, access held until pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            num_errors++;
            report_and_stop();
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("register %h", a), rdata, e);
    endtask
    // count high samples and rising edges of the four clock outputs
    task automatic clocks;
        logic [3:0] cur, prv;
        hi = '{default: 0};
        up = '{default: 0};
        repeat (2) @(posedge pclk);
        prv = {main_clock_out, shifted_clock_out, slow_clock_out,
               fb_clock_sel};
        repeat (192) begin
            @(posedge pclk);
            cur = {main_clock_out, shifted_clock_out, slow_clock_out,
                   fb_clock_sel};
            for (int i = 0; i < 4; i++) begin
                hi[i] += int'(cur[i]);
                up[i] += int'(cur[i] & ~prv[i]);
            end
            prv = cur;
        end
    endtask
    // settle the fabric command, then compare the decoded outputs
    task automatic dyn(input logic [14:0] c, input logic [12:0] e);
        cmd <= c;
        repeat (3) @(posedge pclk);
        chk("delay", 32'(delay_steps_out), 32'(e[12:8]));
        chk("phase", 32'(phase_out), 32'(e[7:4]));
        chk("duty", 32'(duty_out), 32'(e[3:0]));
    endtask

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // free-running reference input for the bypass paths
    always @(posedge pclk) ref_clock_in <= ~ref_clock_in;

    initial begin
        {presetn, psel, penable, pwrite, fb_clock_in} = 5'h00;
        paddr  = 8'h00;
        pwdata = 32'h0;
        cmd    = 15'h0;
        rows = '{{15'h5FF2, 5'h18, 4'hF, 4'h2}, {15'h510E, 5'h1F, 4'h0, 4'hE},
                 {15'h4113, 5'h01, 4'h1, 4'h3}, {15'h4F88, 5'h08, 4'h8, 4'h8},
                 {15'h7B50, 5'h00, 4'h5, 4'h8}, {15'h47A1, 5'h04, 4'hA, 4'h8},
                 {15'h1EF2, 5'h1D, 4'h3, 4'h5}};
        repeat (10) @(posedge pclk);
        chk("lock", 32'(lock), 32'h0);
        chk("duty", 32'(duty_out), 32'h8);
        presetn <= 1'b1;
        rchk(`PDC_CTRL_OFS, 32'h0000_0008);
        rchk(`PDC_DIV_OFS, 32'h0208_0101);
        rchk(`PDC_ADJ_OFS, 32'h0000_8000);
        $display("reset test done");
        apb(1'b1, `PDC_DIV_OFS, 32'h8003_4041);
        rchk(`PDC_DIV_OFS, 32'h8008_4001);
        apb(1'b1, `PDC_DIV_OFS, 32'h0330_0040);
        rchk(`PDC_DIV_OFS, 32'h8030_4040);
        apb(1'b1, `PDC_ADJ_OFS, 32'h0000_561D);
        apb(1'b1, `PDC_ADJ_OFS, 32'h0000_F309);
        rchk(`PDC_ADJ_OFS, 32'h0000_531D);
        apb(1'b1, `PDC_CTRL_OFS, 32'h0000_0018);
        rchk(`PDC_CTRL_OFS, 32'h0000_0008);
        apb(1'b1, `PDC_CTRL_OFS, 32'h0000_0010);
        rchk(`PDC_CTRL_OFS, 32'h0000_0010);
        apb(1'b0, 8'h10, 32'h0);
        chk("pslverr", 32'(rerr), 32'h1);
        chk("prdata", rdata, 32'h0);
        $display("register test done");
        apb(1'b1, `PDC_CTRL_OFS, 32'h0000_000E);
        foreach (rows[i]) dyn(rows[i][27:13], rows[i][12:0]);
        $display("dynamic table test done");
        apb(1'b1, `PDC_CTRL_OFS, 32'h0000_0008);
        dyn(15'h5FF2, {5'h1D, 4'h3, 4'h5});
        $display("static attribute test done");
        apb(1'b1, `PDC_DIV_OFS, 32'h0230_4040);
        apb(1'b1, `PDC_CTRL_OFS, 32'h0000_0009);
        repeat (2) @(posedge pclk);
        chk("lock", 32'(lock), 32'h0);
        apb(1'b1, `PDC_CTRL_OFS, 32'h0000_0008);
        n = 0;
        while (lock !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk("lock wait", 32'(n >= LOCK_N && n <= LOCK_N + 2),
            32'h1);
        $display("lock test done");
        clocks();
        chk("main high", hi[3], 32'h60);
        chk("main rises", up[3], 32'h4);
        chk("shifted high", hi[2], 32'h3C);
        chk("slow high", hi[1], 32'h60);
        chk("slow rises", up[1], 32'h2);
        chk("fb tree rises", up[0], 32'h4);
        apb(1'b1, `PDC_CTRL_OFS, 32'h0000_00F0);
        clocks();
        chk("main bypass", up[3], 32'h60);
        chk("shifted bypass", up[2], 32'h60);
        chk("slow bypass", up[1], 32'h60);
        chk("fb user", hi[0], 32'h0);
        $display("clock output test done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("lock", 32'(lock), 32'h0);
        presetn <= 1'b1;
        rchk(`PDC_CTRL_OFS, 32'h0000_0008);
        rchk(`PDC_DIV_OFS, 32'h0208_0101);
        $display("second reset test done");
        report_and_stop();
    end
endmodule
